// ===== rtl/clk_ctrl_defines.svh
`ifndef CLK_CTRL_DEFINES_SVH
`define CLK_CTRL_DEFINES_SVH

// register byte addresses
`define A_OUTCTL        8'h02
`define A_SEL           8'h04
`define A_SRC           8'h08
`define A_FIRST         8'h0C
`define A_SS4           8'h4C
`define A_SSCNT         8'h50
`define A_STATUS        8'h54
`define A_CFGBASE       8'h60
`define A_FOURTH_LAST   8'h85

// field positions in the output control word
`define F_POL           0
`define F_SHMODE        1
`define F_OS_LO         8
`define F_OE_LO         16

// field positions in the source word
`define F_PRIM          0
`define F_XBYP          1
`define F_SM_LO         2

// field positions in the spread word
`define F_SSEN          0
`define F_SSDIV_LO      8

// reset values
`define R_OUTCTL        32'h0000_0000
`define R_SRC           32'h0000_0000
`define R_FIRST         32'h0000_0000
`define R_SS4           32'h0000_0000
`define R_SSCNT         32'h0000_0000
`define R_CFG           32'h0000_0000

`define N_OUT           7
`define N_CFG           6

`endif

// ===== rtl/clk_ctrl_pkg.sv
package clk_ctrl_pkg;
    typedef enum logic [1:0] {
        SM_MANUAL0 = 2'b00,
        SM_MANUAL1 = 2'b01,
        SM_AUTO    = 2'b10,
        SM_REVERT  = 2'b11
    } switch_mode_e;

    typedef enum logic [1:0] {
        OUT_HIZ     = 2'b00,
        OUT_ENABLED = 2'b01,
        OUT_SUSPEND = 2'b10
    } out_state_e;
endpackage

// ===== rtl/pin_sync.sv
// three-stage synchroniser; a change is accepted once stages two and
// three agree, so stage one feeds only stage two
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         hclk,    // clock
    input  wire logic         hresetn, // async reset, low
    input  wire logic         ce,      // clock enable
    input  wire logic [W-1:0] pin,     // asynchronous input
    output logic      [W-1:0] level    // accepted level
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] lv_q;
    logic [W-1:0] lv_d;

    always_comb begin
        lv_d = lv_q;
        for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                lv_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            lv_q <= '0;
        end else if (ce) begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lv_q <= lv_d;
        end
    end

    assign level = lv_q;
endmodule

// ===== rtl/clock_config_output_control.sv
// Operation
// - select pins codes 000..101 choose stored setting zero to five
// - host may rewrite settings live; device accepts them at once
// - crystal bypass bit set bypasses the oscillator on first input
// - reference is primary bit xor input choice pin in manual mode
// - mode 0x manual, 10 auto one-way, 11 auto revertive
// - pin polarity bit at 0x02 resets 0, active low; 1 active high
// - shutdown mode bit picks global shutdown or per-output control
// - enable bit 0 gives high impedance unless global shutdown
// - mode 0: suspended when pin differs from polarity
// - mode 1, pin 0: enabled if polarity 0, suspended if 1
// - fourth loop spread runs only while spread enable bit is 1
// - fourth loop spread fields sit within 0x4C to 0x85
// - 8-bit spread divider sets modulation rate as input over 4N
// - 16-bit spread feedback counter sets the modulated loop count
// - first loop step field zero disables spread, nonzero enables
//
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`include "clk_ctrl_defines.svh"

module clock_config_output_control (
    input  wire logic        hclk,               // 40 MHz clock
    input  wire logic        hresetn,            // async reset, low
    input  wire logic        clk_en,             // freezes state when low
    input  wire logic        hsel,               // ahb slave select
    input  wire logic [7:0]  haddr,              // ahb byte address
    input  wire logic [1:0]  htrans,             // ahb transfer type
    input  wire logic        hwrite,             // ahb write
    input  wire logic [2:0]  hsize,              // ahb size
    input  wire logic [31:0] hwdata,             // ahb write data
    input  wire logic        hready,             // ahb bus ready
    output logic      [31:0] hrdata,             // ahb read data
    output logic             hreadyout,          // ahb slave ready
    output logic             hresp,              // ahb response
    input  wire logic [2:0]  config_sel_pins,    // setting select pins
    input  wire logic        input_choice_pin,   // primary/secondary pick
    input  wire logic        shutdown_enable_pin,// shutdown/enable pin
    input  wire logic        primary_alive,      // primary clock present
    input  wire logic        secondary_alive,    // secondary present
    output logic      [2:0]  active_setting,     // setting in use
    output logic             ref_is_second,      // ref is second input
    output logic             crystal_bypass,     // oscillator bypassed
    output logic             plls_shutdown,      // global shutdown
    output logic      [13:0] clock_output_n,     // two bits per output
    output logic             fourth_spread_on,   // fourth loop spread
    output logic      [7:0]  spread_ref_divider, // mod divider
    output logic      [15:0] spread_feedback_counter, // mod count
    output logic             first_spread_on     // first loop spread
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] sel_s;
    logic       choice_s;
    logic       sd_s;
    logic       palive_s;
    logic       salive_s;

    pin_sync #(.W(7)) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (clk_en),
        .pin     ({config_sel_pins, input_choice_pin,
                   shutdown_enable_pin, primary_alive, secondary_alive}),
        .level   ({sel_s, choice_s, sd_s, palive_s, salive_s})
    );

    // ------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------
    logic        wr_pend_q, wr_pend_d;
    logic [7:0]  wa_q, wa_d;
    logic [31:0] rd_q, rd_d;
    logic [31:0] outctl_q, outctl_d;
    logic [31:0] src_q, src_d;
    logic [31:0] first_q, first_d;
    logic [31:0] ss4_q, ss4_d;
    logic [31:0] sscnt_q, sscnt_d;
    logic [31:0] cfg_q [`N_CFG];
    logic [31:0] cfg_d [`N_CFG];

    logic        take;
    logic [31:0] status_w;

    // control word decoded on its word-aligned address
    localparam logic [7:0] outctl_word = `A_OUTCTL & 8'hFC;

    function automatic logic is_cfg(input logic [7:0] a);
        return a >= `A_CFGBASE && a < `A_CFGBASE + 8'(4 * `N_CFG);
    endfunction

    function automatic logic [2:0] cfg_idx(input logic [7:0] a);
        logic [7:0] off;
        off = a - `A_CFGBASE;
        return off[4:2];
    endfunction

    assign take = hsel && hready && htrans[1];

    always_comb begin
        wr_pend_d = 1'b0;
        wa_d      = wa_q;
        rd_d      = rd_q;
        outctl_d  = outctl_q;
        src_d     = src_q;
        first_d   = first_q;
        ss4_d     = ss4_q;
        sscnt_d   = sscnt_q;
        for (int i = 0; i < `N_CFG; i++) begin
            cfg_d[i] = cfg_q[i];
        end
        if (wr_pend_q) begin
            unique case (wa_q)
                outctl_word: outctl_d = hwdata;
                `A_SRC:    src_d    = hwdata;
                `A_FIRST:  first_d  = hwdata;
                `A_SS4:    ss4_d    = hwdata;
                `A_SSCNT:  sscnt_d  = {16'h0000, hwdata[15:0]};
                default: begin
                    if (is_cfg(wa_q)) begin
                        cfg_d[cfg_idx(wa_q)] = hwdata;
                    end
                end
            endcase
        end
        if (take) begin
            wr_pend_d = hwrite;
            wa_d      = {haddr[7:2], 2'b00};
            rd_d      = 32'h0000_0000;
            if (!hwrite) begin
                unique case ({haddr[7:2], 2'b00})
                    outctl_word: rd_d = outctl_q;
                    `A_SEL:    rd_d = {29'h0, sel_s};
                    `A_SRC:    rd_d = src_q;
                    `A_FIRST:  rd_d = first_q;
                    `A_SS4:    rd_d = ss4_q;
                    `A_SSCNT:  rd_d = sscnt_q;
                    `A_STATUS: rd_d = status_w;
                    default: begin
                        if (is_cfg({haddr[7:2], 2'b00})) begin
                            rd_d = cfg_q[cfg_idx({haddr[7:2], 2'b00})];
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wa_q      <= 8'h00;
            rd_q      <= 32'h0000_0000;
            outctl_q  <= `R_OUTCTL;
            src_q     <= `R_SRC;
            first_q   <= `R_FIRST;
            ss4_q     <= `R_SS4;
            sscnt_q   <= `R_SSCNT;
            for (int i = 0; i < `N_CFG; i++) begin
                cfg_q[i] <= `R_CFG;
            end
        end else if (clk_en) begin
            wr_pend_q <= wr_pend_d;
            wa_q      <= wa_d;
            rd_q      <= rd_d;
            outctl_q  <= outctl_d;
            src_q     <= src_d;
            first_q   <= first_d;
            ss4_q     <= ss4_d;
            sscnt_q   <= sscnt_d;
            for (int i = 0; i < `N_CFG; i++) begin
                cfg_q[i] <= cfg_d[i];
            end
        end
    end

    assign hrdata    = rd_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ------------------------------------------------------------
    // setting selection and reference choice
    // ------------------------------------------------------------
    logic [2:0] act_q, act_d;
    logic       sec_q, sec_d;
    logic       ref_q, ref_d;
    logic       byp_q, byp_d;
    clk_ctrl_pkg::switch_mode_e mode;

    assign mode = clk_ctrl_pkg::switch_mode_e'(src_q[`F_SM_LO +: 2]);

    always_comb begin
        act_d = act_q;
        if (sel_s <= 3'h5) begin
            act_d = sel_s;
        end
        sec_d = sec_q;
        unique case (mode)
            clk_ctrl_pkg::SM_MANUAL0,
            clk_ctrl_pkg::SM_MANUAL1: sec_d = choice_s;
            clk_ctrl_pkg::SM_AUTO: begin
                if (!palive_s && salive_s) begin
                    sec_d = 1'b1;
                end
            end
            clk_ctrl_pkg::SM_REVERT: begin
                if (!palive_s && salive_s) begin
                    sec_d = 1'b1;
                end else if (palive_s) begin
                    sec_d = 1'b0;
                end
            end
        endcase
        // reference is primary xor secondary pick
        ref_d = src_q[`F_PRIM] ^ sec_d;
        byp_d = src_q[`F_XBYP];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act_q <= 3'h0;
            sec_q <= 1'b0;
            ref_q <= 1'b0;
            byp_q <= 1'b0;
        end else if (clk_en) begin
            act_q <= act_d;
            sec_q <= sec_d;
            ref_q <= ref_d;
            byp_q <= byp_d;
        end
    end

    assign active_setting = act_q;
    assign ref_is_second  = ref_q;
    assign crystal_bypass = byp_q;

    // ------------------------------------------------------------
    // output enables and spread controls
    // ------------------------------------------------------------
    logic [13:0] outs_q, outs_d;
    logic        gsd_q, gsd_d;
    logic        ss4on_q, ss4on_d;
    logic [7:0]  ssdiv_q, ssdiv_d;
    logic [15:0] sscnt_o_q, sscnt_o_d;
    logic        ss1on_q, ss1on_d;
    logic        pol, shm, os, oe;

    assign pol = outctl_q[`F_POL];
    assign shm = outctl_q[`F_SHMODE];
    assign status_w = {16'h0000, 8'h00, 3'h0, gsd_q, sec_q, act_q};

    always_comb begin
        os = 1'b0;
        oe = 1'b0;
        // pin high in mode 1 suspends all
        gsd_d = shm && sd_s;
        for (int n = 0; n < `N_OUT; n++) begin
            os = outctl_q[`F_OS_LO + n];
            oe = outctl_q[`F_OE_LO + n];
            if (gsd_d) begin
                outs_d[2*n +: 2] = clk_ctrl_pkg::OUT_SUSPEND;
            end else if (!os) begin
                outs_d[2*n +: 2] = clk_ctrl_pkg::OUT_HIZ;
            end else if (!oe) begin
                outs_d[2*n +: 2] = clk_ctrl_pkg::OUT_ENABLED;
            end else if (sd_s != pol) begin
                outs_d[2*n +: 2] = clk_ctrl_pkg::OUT_SUSPEND;
            end else begin
                outs_d[2*n +: 2] = clk_ctrl_pkg::OUT_ENABLED;
            end
        end
        // fourth loop spread fields at 0x4C and 0x50
        ss4on_d   = ss4_q[`F_SSEN];
        ssdiv_d   = ss4_q[`F_SSDIV_LO +: 8];
        sscnt_o_d = sscnt_q[15:0];
        ss1on_d   = first_q[3:0] != 4'h0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            outs_q    <= 14'h0000;
            gsd_q     <= 1'b0;
            ss4on_q   <= 1'b0;
            ssdiv_q   <= 8'h00;
            sscnt_o_q <= 16'h0000;
            ss1on_q   <= 1'b0;
        end else if (clk_en) begin
            outs_q    <= outs_d;
            gsd_q     <= gsd_d;
            ss4on_q   <= ss4on_d;
            ssdiv_q   <= ssdiv_d;
            sscnt_o_q <= sscnt_o_d;
            ss1on_q   <= ss1on_d;
        end
    end

    assign clock_output_n          = outs_q;
    assign plls_shutdown           = gsd_q;
    assign fourth_spread_on        = ss4on_q;
    assign spread_ref_divider      = ssdiv_q;
    assign spread_feedback_counter = sscnt_o_q;
    assign first_spread_on         = ss1on_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_sel_ok;
        clk_en && sel_s <= 3'h5;
    endsequence

    property p_sel_load;
        @(posedge hclk) disable iff (!hresetn)
        s_sel_ok |=> active_setting == $past(sel_s);
    endproperty
    a_sel_load: assert property (p_sel_load)
        else $error("active setting did not follow select");

    property p_sel_resv;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && sel_s > 3'h5) |=> $stable(active_setting);
    endproperty
    a_sel_resv: assert property (p_sel_resv)
        else $error("reserved select changed setting");

    property p_manual_ref;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && !src_q[3]) |=>
            ref_is_second == ($past(src_q[0]) ^ $past(choice_s));
    endproperty
    a_manual_ref: assert property (p_manual_ref)
        else $error("manual reference not primary xor choice");

    property p_auto_hold;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && mode == clk_ctrl_pkg::SM_AUTO && sec_q) |=> sec_q;
    endproperty
    a_auto_hold: assert property (p_auto_hold)
        else $error("one-way auto mode reverted");

    property p_gsd;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && shm && sd_s) |=> plls_shutdown
            && clock_output_n[1:0] == clk_ctrl_pkg::OUT_SUSPEND;
    endproperty
    a_gsd: assert property (p_gsd)
        else $error("global shutdown not applied");

    property p_hiz;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && !gsd_d && !outctl_q[`F_OS_LO]) |=>
            clock_output_n[1:0] == clk_ctrl_pkg::OUT_HIZ;
    endproperty
    a_hiz: assert property (p_hiz)
        else $error("disabled output not high impedance");

    property p_nopin;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && !gsd_d && outctl_q[`F_OS_LO] && !outctl_q[`F_OE_LO])
            |=> clock_output_n[1:0] == clk_ctrl_pkg::OUT_ENABLED;
    endproperty
    a_nopin: assert property (p_nopin)
        else $error("pin-free output not enabled");

    property p_pinpol;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && !gsd_d && outctl_q[`F_OS_LO] && outctl_q[`F_OE_LO])
            |=> (clock_output_n[1:0] == clk_ctrl_pkg::OUT_SUSPEND)
                == ($past(sd_s) != $past(pol));
    endproperty
    a_pinpol: assert property (p_pinpol)
        else $error("pin polarity control wrong");

    property p_ss4;
        @(posedge hclk) disable iff (!hresetn)
        clk_en |=> fourth_spread_on == $past(ss4_q[0]);
    endproperty
    a_ss4: assert property (p_ss4)
        else $error("fourth loop spread not following enable");

    property p_ss1;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && first_q[3:0] == 4'h0) |=> !first_spread_on;
    endproperty
    a_ss1: assert property (p_ss1)
        else $error("zero step left first loop spread on");
endmodule

// ===== tb/board_pins.sv
// ----------------------------------------------------------------
// board side: drives select, choice, enable and clock-alive pins
// ----------------------------------------------------------------
module board_pins (
    input  wire logic       hclk,    // clock
    input  wire logic       hresetn, // async reset, low
    input  wire logic [6:0] req,     // wanted levels, same order as pins
    input  wire logic       slow,    // hold off each change a while
    output logic      [6:0] pins     // {sec_alive,prim_alive,sd,choice,sel}
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [1:0] wait_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pins   <= 7'h60;
            wait_q <= 2'h0;
        end else if (req != pins && slow && wait_q != 2'h3) begin
            wait_q <= wait_q + 2'h1;
        end else begin
            wait_q <= 2'h0;
            if (req[2:1] != 2'b11) begin
                pins <= req;
            end
        end
    end
endmodule

// ===== tb/clock_config_output_control_tb.sv
`include "clk_ctrl_defines.svh"

module clock_config_output_control_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [6:0]  req = 7'h60;
    logic [6:0]  pins;
    logic        slow = 1'b0;
    logic        clk_en = 1'b1;
    logic [31:0] rb;
    logic [2:0]  active_setting;
    logic        ref_is_second;
    logic        crystal_bypass;
    logic        plls_shutdown;
    logic [13:0] clock_output_n;
    logic        fourth_spread_on;
    logic [7:0]  spread_ref_divider;
    logic [15:0] spread_feedback_counter;
    logic        first_spread_on;
    logic [31:0] d;
    logic [6:0]  os;
    logic [6:0]  oe;
    logic [3:0]  step;
    integer      seed;
    int          n_fail = 0;
    int          checks_done = 0;

    always #12.5 hclk = ~hclk;

    board_pins board_pins_i (.hclk(hclk), .hresetn(hresetn), .req(req),
        .slow(slow), .pins(pins));

    clock_config_output_control clock_config_output_control_i (
        .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .config_sel_pins(pins[2:0]), .input_choice_pin(pins[3]),
        .shutdown_enable_pin(pins[4]), .primary_alive(pins[5]),
        .secondary_alive(pins[6]), .active_setting(active_setting),
        .ref_is_second(ref_is_second), .crystal_bypass(crystal_bypass),
        .plls_shutdown(plls_shutdown), .clock_output_n(clock_output_n),
        .fourth_spread_on(fourth_spread_on),
        .spread_ref_divider(spread_ref_divider),
        .spread_feedback_counter(spread_feedback_counter),
        .first_spread_on(first_spread_on));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [13:0] exp_out(input logic sh, pol, sd,
                                            input logic [6:0] s, e);
        logic [13:0] r;
        for (int k = 0; k < 7; k++) begin
            if (sh && sd) r[2*k+:2] = clk_ctrl_pkg::OUT_SUSPEND;
            else if (!s[k]) r[2*k+:2] = clk_ctrl_pkg::OUT_HIZ;
            else if (!e[k]) r[2*k+:2] = clk_ctrl_pkg::OUT_ENABLED;
            else if (sh ? pol : (sd != pol))
                r[2*k+:2] = clk_ctrl_pkg::OUT_SUSPEND;
            else r[2*k+:2] = clk_ctrl_pkg::OUT_ENABLED;
        end
        return r;
    endfunction

    task automatic check(input string w, input logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", w, e, s);
        end
    endtask

    task automatic bus(input logic wr_en, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd_v);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr_en;
        hsize <= 3'h2;
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
        rd_v = hrdata;
        check("hresp", hresp, 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] x;
        bus(1'b1, a, v, x);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        bus(1'b0, a, 32'h0, v);
    endtask

    task automatic settle;
        repeat (12) @(posedge hclk);
    endtask

    task automatic end_test(input string w);
        $display("test %s done, mismatches so far %0d", w, n_fail);
    endtask

    task close_out;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #(25 * 20000);
        n_fail++;
        close_out;
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 32'hadfc;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check("out_rst", clock_output_n, 32'h0);
        rd(`A_OUTCTL, d);
        check("outctl_rst", d, `R_OUTCTL);
        rd(`A_SS4, d);
        check("ss4_rst", d, `R_SS4);
        wr(8'hF0, 32'hA5A5_5A5A);
        rd(8'hF0, d);
        check("unmapped", d, 32'h0);
        end_test("reset");

        for (int i = 0; i < 32; i++) begin
            os = 7'($random(seed));
            oe = 7'($random(seed));
            req[4] <= i[2];
            wr(`A_OUTCTL, {9'h0, oe, 1'b0, os, 6'h0, i[0], i[1]});
            settle;
            check("outs", clock_output_n,
                  32'(exp_out(i[0], i[1], i[2], os, oe)));
            check("shut", plls_shutdown, i[0] & i[2]);
        end
        end_test("outputs");

        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            req[3] <= i[1];
            wr(`A_SRC, {28'h0, 1'b0, i[2], d[0], i[0]});
            settle;
            check("ref", ref_is_second, i[0] ^ i[1]);
            check("bypass", crystal_bypass, d[0]);
            rd(`A_STATUS, d);
            check("st_ref", d[3], i[1]);
        end
        req[3] <= 1'b0;
        for (int m = 3; m > 1; m--) begin
            wr(`A_SRC, {28'h0, 2'(m), 2'b00});
            settle;
            check("auto_a", ref_is_second, 32'h0);
            req[5] <= 1'b0;
            settle;
            check("auto_b", ref_is_second, 32'h1);
            req[5] <= 1'b1;
            settle;
            check("auto_c", ref_is_second, 32'(m == 2));
        end
        end_test("source");

        for (int i = 0; i < 6; i++) begin
            d = $random(seed);
            step = (i == 0) ? 4'h0 : d[3:0];
            // bit 4 above the step field kept at 1; bits 31..5 are random
            wr(`A_FIRST, {d[31:5], 1'b1, step});
            wr(`A_SS4, {16'h0, d[15:8], 7'h0, i[0]});
            wr(`A_SSCNT, {16'h0, d[31:16]});
            settle;
            check("first", first_spread_on, 32'(step != 4'h0));
            check("fourth", fourth_spread_on, i[0]);
            check("div", spread_ref_divider, d[15:8]);
            check("cnt", spread_feedback_counter, d[31:16]);
            rd(`A_SS4, rb);
            check("ss4_rb", rb, {16'h0, d[15:8], 7'h0, i[0]});
        end
        end_test("spread");

        for (int c = 0; c < 6; c++) begin
            slow <= c[0];
            req[2:0] <= c[2:0];
            settle;
            check("setting", active_setting, c[2:0]);
            rd(`A_STATUS, d);
            check("st_set", d[2:0], c[2:0]);
            os = {1'b0, 6'($random(seed))};
            wr(`A_CFGBASE + 8'(4 * c), {25'h0, os});
            rd(`A_CFGBASE + 8'(4 * c), d);
            check("cfg_rb", d, {25'h0, os});
        end
        end_test("select");

        clk_en <= 1'b0;
        req[2:0] <= 3'h2;
        settle;
        check("frozen", active_setting, 32'h5);
        clk_en <= 1'b1;
        settle;
        check("thawed", active_setting, 32'h2);
        end_test("enable");
        close_out;
    end
endmodule
